// ===== rtl/usb_chan_engine.sv
// How it works
// - Bulk OUT checks FIFO data, frame time first
// - Bulk-only channel always bulk, no kind field
// - OUT packet is min of max, remaining
// - OUT ACK sets ok flag, frees FIFO
// - OUT NAK keeps FIFO, same transaction repeats
// - OUT STALL clears execute, STALL code, halted
// - OUT no handshake: retry code, error flag
// - Periodic OUT also checks token period
// - Interrupt OUT handled like bulk OUT, but also waits for token period
// - Iso OUT ok and free after send
// - Iso OUT starved: skip, error, starved code
// - Bulk IN checks FIFO space, frame time
// - IN expected length is min of both
// - Full IN packet: ACK, ok flag, commit
// - Short IN: ACK, halt, short code, commit
// - IN NAK: no flag, FIFO unchanged
// - IN STALL: clear execute, STALL, halted
// - Babble: no handshake, halt, babble, discard
// - Toggle mismatch: ACK, retry code, discard
// - IN link errors: no handshake, retry code
// - Third retry fault in row halts
// - OUT token then data, endpoint answers
`timescale 1ns/1ps
`include "usb_chan_map.svh"
module usb_chan_engine #(
    parameter bit BULK_ONLY = 1'b0
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Scheduler and frame timing
    input wire logic chanSel,
    input wire logic intervalDue,
    input wire logic frameRoom,
    // FIFO occupancy and updates
    input wire logic [15:0] fifoValid,
    input wire logic [15:0] fifoFree,
    output logic fifoRelease,
    output logic fifoCommit,
    output logic [10:0] fifoLen,
    // Packet layer
    output logic tokReq,
    output logic tokIn,
    output logic [10:0] tokLen,
    input wire logic linkDone,
    input wire logic [2:0] linkResp,
    input wire logic [10:0] rxLen,
    output logic hsAck,
    // Engine status
    output logic busy
);

    ////////////////////////////////////////////////////////////////////
    // Registers
    logic exec_q, exec_d; // Execute transfer bit
    logic [1:0] kind_q; // Transfer kind field
    logic dir_q; // Direction, high for IN
    logic [10:0] maxPkt_q; // Maximum packet length
    logic [31:0] total_q, total_d; // Remaining transfer length
    logic [2:0] flags_q, flags_d; // Channel event flags
    logic [2:0] result_q, result_d; // Transaction result code
    logic [1:0] retry_q, retry_d; // Consecutive retry faults
    usb_chan_pkg::state_t state_q, state_d;
    logic [31:0] rdata_q;
    logic tokReq_q, hsAck_q, rel_q, com_q;
    logic [10:0] len_q, fLen_q;

    ////////////////////////////////////////////////////////////////////
    // Bus decode
    wire wrEn = psel && penable && pwrite;
    wire setup = psel && !penable;
    wire selCfg = paddr == `REG_CONFIG;
    wire selMax = paddr == `REG_MAXPKT;
    wire selTot = paddr == `REG_TOTAL;
    wire selEv = paddr == `REG_EVENTS;
    wire selRes = paddr == `REG_RESULT;
    wire mapped = selCfg || selMax || selTot || selEv || selRes;
    wire wrCfg = wrEn && selCfg;
    wire [2:0] evClr = (wrEn && selEv) ? pwdata[2:0] : 3'h0;

    wire [1:0] kind = BULK_ONLY ? `KIND_BULK : kind_q;
    wire isIso = kind == `KIND_ISO;
    wire [1:0] kindRd = BULK_ONLY ? 2'h0 : kind_q;
    wire [31:0] cfgRd = {28'h0, dir_q, kindRd, exec_q};
    wire [31:0] rdMux = selCfg ? cfgRd :
                        selMax ? {21'h0, maxPkt_q} :
                        selTot ? total_q :
                        selEv ? {29'h0, flags_q} :
                        selRes ? {29'h0, result_q} : 32'h0;

    ////////////////////////////////////////////////////////////////////
    // Launch checks
    // packet length is smaller value
    wire totSmall = total_q < {21'h0, maxPkt_q};
    wire [10:0] pktLen = totSmall ? total_q[10:0] : maxPkt_q;
    wire dataOk = fifoValid >= {5'h0, pktLen};
    wire spaceOk = fifoFree >= {5'h0, pktLen};
    // periodic kinds wait for token period
    wire periodOk = (kind == `KIND_BULK) || intervalDue;
    wire tryNow = state_q == usb_chan_pkg::ST_IDLE && chanSel && exec_q;
    // FIFO and frame time gate launch
    wire bufOk = dir_q ? spaceOk : dataOk;
    wire launch = tryNow && frameRoom && periodOk && bufOk;
    // iso OUT short of data is skipped
    wire starve = tryNow && frameRoom && periodOk && !dir_q && isIso &&
                  !dataOk;

    ////////////////////////////////////////////////////////////////////
    // Completion decode
    wire fin = state_q == usb_chan_pkg::ST_WAIT && linkDone;
    wire outFin = fin && !dir_q;
    wire inFin = fin && dir_q;
    wire rAck = linkResp == `RSP_ACK;
    wire rNak = linkResp == `RSP_NAK;
    wire rStall = linkResp == `RSP_STALL;
    wire rData = linkResp == `RSP_DATA;
    wire rTog = linkResp == `RSP_TOGGLE;
    // iso OUT done once data is sent
    wire isoDone = outFin && isIso;
    // OUT ACK frees the sent bytes
    wire outOk = outFin && !isIso && rAck;
    // NAK leaves everything for a repeat
    wire outStall = outFin && !isIso && rStall;
    // anything else is a retry fault
    wire outFault = outFin && !isIso && !rAck && !rNak && !rStall;
    wire inLong = rxLen > len_q;
    wire inShortL = rxLen < len_q;
    wire inOk = inFin && rData && !inLong && !inShortL;
    wire inShort = inFin && rData && inShortL;
    wire inBabble = inFin && rData && inLong;
    wire inStall = inFin && rStall;
    wire inTog = inFin && rTog;
    wire inFault = inFin && !rData && !rStall && !rTog && !rNak;
    wire doOk = isoDone || outOk || inOk;
    wire doRetry = outFault || inTog || inFault;
    // third fault in a row halts
    wire retryHit = doRetry && retry_q == `RETRY_LAST;
    wire doStall = outStall || inStall;
    wire doHalt = doStall || inShort || inBabble || retryHit;
    wire newGo = wrCfg && pwdata[`CFG_EXEC] && !exec_q;
    wire [10:0] doneLen = dir_q ? rxLen : len_q;
    wire moved = doOk || inShort;

    ////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        state_d = state_q;
        if (launch) begin
            state_d = usb_chan_pkg::ST_WAIT;
        end else if (fin) begin
            state_d = usb_chan_pkg::ST_IDLE;
        end
        // Software write first, hardware clear overrides
        exec_d = wrCfg ? pwdata[`CFG_EXEC] : exec_q;
        if (doHalt) begin
            exec_d = 1'b0;
        end
        total_d = total_q;
        if (wrEn && selTot) begin
            total_d = pwdata;
        end else if (moved) begin
            total_d = total_q - {21'h0, doneLen};
        end
        // Set wins over a clearing write
        flags_d = flags_q & ~evClr;
        if (doOk) begin
            flags_d[`EV_OK] = 1'b1;
        end
        if (doRetry || starve) begin
            flags_d[`EV_ERR] = 1'b1;
        end
        if (doHalt) begin
            flags_d[`EV_HALT] = 1'b1;
        end
        result_d = result_q;
        if (doStall) begin
            result_d = `RC_STALL;
        end else if (inShort) begin
            result_d = `RC_SHORT;
        end else if (inBabble) begin
            result_d = `RC_BABBLE;
        end else if (doRetry) begin
            result_d = `RC_RETRY;
        end else if (starve) begin
            result_d = `RC_STARVED;
        end
        // retry count clears on success or start
        retry_d = retry_q;
        if (newGo || moved || retryHit) begin
            retry_d = 2'h0;
        end else if (doRetry) begin
            retry_d = retry_q + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_q <= usb_chan_pkg::ST_IDLE;
            exec_q <= 1'b0;
            kind_q <= `KIND_BULK;
            dir_q <= 1'b0;
            maxPkt_q <= `MAXPKT_RST;
            total_q <= 32'h0;
            flags_q <= 3'h0;
            result_q <= `RC_NONE;
            retry_q <= 2'h0;
        end else begin
            state_q <= state_d;
            exec_q <= exec_d;
            if (wrCfg) begin
                kind_q <= pwdata[`CFG_KIND_HI:`CFG_KIND_LO];
                dir_q <= pwdata[`CFG_DIR];
            end
            if (wrEn && selMax) begin
                maxPkt_q <= pwdata[10:0];
            end
            total_q <= total_d;
            flags_q <= flags_d;
            result_q <= result_d;
            retry_q <= retry_d;
        end
    end

    // Read data captured in the setup cycle
    always_ff @(posedge clock) begin
        if (!rstn) begin
            rdata_q <= 32'h0;
        end else if (setup) begin
            rdata_q <= rdMux;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Link and FIFO strobes
    always_ff @(posedge clock) begin
        if (!rstn) begin
            tokReq_q <= 1'b0;
            hsAck_q <= 1'b0;
            rel_q <= 1'b0;
            com_q <= 1'b0;
            len_q <= 11'h0;
            fLen_q <= 11'h0;
        end else begin
            tokReq_q <= launch;
            if (launch) begin
                len_q <= pktLen;
            end
            hsAck_q <= inOk || inShort || inTog;
            rel_q <= isoDone || outOk;
            com_q <= inOk || inShort;
            if (moved) begin
                fLen_q <= doneLen;
            end
        end
    end

    assign prdata = rdata_q;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign tokReq = tokReq_q;
    assign tokIn = dir_q;
    assign tokLen = len_q;
    assign hsAck = hsAck_q;
    assign fifoRelease = rel_q;
    assign fifoCommit = com_q;
    assign fifoLen = fLen_q;
    assign busy = state_q == usb_chan_pkg::ST_WAIT;

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence sHalted;
        !exec_q && flags_q[`EV_HALT];
    endsequence
    // Iso OUT takes any answer as done, so only a halting STALL counts
    sequence sStallSeen;
        doStall;
    endsequence

    // OUT launch needs data and frame time
    a_launch_gate: assert property (tokReq && !tokIn |->
        $past(frameRoom) && $past(dataOk))
        else $error("OUT token without data or frame time");
    a_token_len: assert property (tokReq |-> tokLen <= maxPkt_q)
        else $error("token length above maximum");
    // ACK frees FIFO and sets ok
    a_out_ack: assert property (outOk |=>
        fifoRelease && flags_q[`EV_OK] && fifoLen == $past(len_q))
        else $error("OUT ACK did not free FIFO");
    a_out_nak: assert property (outFin && rNak && !isIso |=>
        !fifoRelease && flags_q == $past(flags_q) && exec_q)
        else $error("OUT NAK changed state");
    a_stall_halt: assert property (sStallSeen |=> sHalted and
        result_q == `RC_STALL ##1 !tokReq)
        else $error("STALL did not halt channel");
    a_iso_starve: assert property (starve |=> !tokReq &&
        flags_q[`EV_ERR] && result_q == `RC_STARVED)
        else $error("starved iso OUT not flagged");
    a_babble: assert property (inBabble |=> !hsAck && !fifoCommit &&
        result_q == `RC_BABBLE)
        else $error("babble mishandled");
    a_toggle: assert property (inTog |=> hsAck && !fifoCommit &&
        flags_q[`EV_ERR])
        else $error("toggle mismatch mishandled");
    a_retry_limit: assert property (doRetry && retry_q == `RETRY_LAST
        |=> sHalted and retry_q == 2'h0)
        else $error("third retry fault did not halt");
    a_bulk_only: assert property (BULK_ONLY && tryNow && frameRoom &&
        bufOk |=> tokReq && kindRd == 2'h0)
        else $error("bulk-only channel shows a kind");
endmodule

// ===== rtl/usb_chan_map.svh
`ifndef USB_CHAN_MAP_SVH
`define USB_CHAN_MAP_SVH
// Register byte offsets
`define REG_CONFIG 12'h000
`define REG_MAXPKT 12'h004
`define REG_TOTAL 12'h008
`define REG_EVENTS 12'h00C
`define REG_RESULT 12'h010
// Configuration field positions
`define CFG_EXEC 0
`define CFG_KIND_LO 1
`define CFG_KIND_HI 2
`define CFG_DIR 3
// Event flag positions
`define EV_OK 0
`define EV_ERR 1
`define EV_HALT 2
// Transfer kinds
`define KIND_BULK 2'h0
`define KIND_INTR 2'h1
`define KIND_ISO 2'h2
// Result codes
`define RC_NONE 3'h0
`define RC_STALL 3'h1
`define RC_RETRY 3'h2
`define RC_SHORT 3'h3
`define RC_BABBLE 3'h4
`define RC_STARVED 3'h5
// Link answers
`define RSP_ACK 3'h0
`define RSP_NAK 3'h1
`define RSP_STALL 3'h2
`define RSP_FAULT 3'h3
`define RSP_DATA 3'h4
`define RSP_TOGGLE 3'h5
// Retry count at which the next fault in a row halts the transfer
`define RETRY_LAST 2'h2
// Reset values
`define MAXPKT_RST 11'h040
`endif

// ===== rtl/usb_chan_pkg.sv
package usb_chan_pkg;
    // Engine states
    typedef enum logic {ST_IDLE, ST_WAIT} state_t;
endpackage

// ===== tb/usb_chan_engine_tb.sv
`timescale 1ns/1ps
`include "usb_chan_map.svh"
module usb_chan_engine_tb;
    // Design and partner signals
    logic clock, rstn, psel, penable, pwrite, pready, pslverr, chanSel;
    logic intervalDue, frameRoom, fifoRelease, fifoCommit, tokReq, tokIn;
    logic linkDone, hsAck, busy, slvErr, lastIn;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, expTot, expCfg, prdataB, qB;
    logic [15:0] fifoValid, fifoFree;
    logic [10:0] fifoLen, tokLen, rxLen, lenSel, lastTok, lastFifo;
    logic [2:0] linkResp, respSel, delaySel, expRc, expEv;
    // Bench counters
    int err_total, n_tests, seed, nTok, nRel, nCom, nHs, rtCnt, d;

    usb_chan_engine i_usb_chan_engine (
        .clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chanSel(chanSel),
        .intervalDue(intervalDue), .frameRoom(frameRoom),
        .fifoValid(fifoValid), .fifoFree(fifoFree),
        .fifoRelease(fifoRelease), .fifoCommit(fifoCommit),
        .fifoLen(fifoLen), .tokReq(tokReq), .tokIn(tokIn), .tokLen(tokLen),
        .linkDone(linkDone), .linkResp(linkResp), .rxLen(rxLen),
        .hsAck(hsAck), .busy(busy));
    usb_peer_model i_usb_peer_model (
        .clock(clock), .rstn(rstn), .tokReq(tokReq), .tokIn(tokIn),
        .respSel(respSel), .lenSel(lenSel), .delaySel(delaySel),
        .linkDone(linkDone), .linkResp(linkResp), .rxLen(rxLen));
    // Bulk-only probe on the same bus and link
    usb_chan_engine #(.BULK_ONLY(1'b1)) i_usb_chan_engine_bulk (
        .clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdataB),
        .pready(), .pslverr(), .chanSel(chanSel),
        .intervalDue(intervalDue), .frameRoom(frameRoom),
        .fifoValid(fifoValid), .fifoFree(fifoFree),
        .fifoRelease(), .fifoCommit(), .fifoLen(), .tokReq(), .tokIn(),
        .tokLen(), .linkDone(linkDone), .linkResp(linkResp), .rxLen(rxLen),
        .hsAck(), .busy());
    ////////////////////////////////////////////////////////////
    initial begin
        clock = 1'h0;
        forever #2.5 clock = ~clock;
    end
    // Count engine pulses and keep what they carry
    always @(posedge clock) begin
        if (tokReq === 1'h1) begin
            nTok++;
            lastTok = tokLen;
            lastIn = tokIn;
        end
        if (fifoRelease === 1'h1 || fifoCommit === 1'h1) lastFifo = fifoLen;
        nRel += (fifoRelease === 1'h1);
        nCom += (fifoCommit === 1'h1);
        nHs += (hsAck === 1'h1);
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic hang();
        err_total++;
        final_report();
    endtask
    function automatic int rnd(input int n);
        return $unsigned($random(seed)) % n;
    endfunction
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] dat);
        int n;
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= dat;
        @(posedge clock);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'h1 && n < 50);
        if (pready !== 1'h1) hang();
        q = prdata;
        qB = prdataB;
        slvErr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clock);
    endtask
    // Halting outcome: execute drops, retry count restarts
    task automatic halt(input logic [2:0] rc);
        expEv = expEv | 3'h4;
        expRc = rc;
        expCfg[0] = 1'h0;
        rtCnt = 0;
    endtask
    // Set up the channel, select it once and judge the outcome
    task automatic runTx(input logic fresh, sure, dir, input logic [1:0] kind,
        input logic [10:0] maxp, input logic [31:0] tot,
        input logic [2:0] resp, input logic [1:0] rxMode, input logic sv);
        logic [10:0] len, rx;
        logic room, due, go, st, ok, hs, com;
        int t0, r0, c0, h0, n;
        len = (tot < 32'(maxp)) ? tot[10:0] : maxp;
        rx = (rxMode == 2'h1) ? len - 11'h1 : len + 11'(rxMode[1]);
        room = sure || rnd(5) != 0;
        due = sure || rnd(3) != 0;
        // A short FIFO refuses the launch, except iso OUT which is starved
        go = room && (kind == `KIND_BULK || due) &&
            (!sv || !dir && kind == `KIND_ISO);
        st = sv && !dir && kind == `KIND_ISO;
        apb(1'h1, `REG_MAXPKT, {21'h0, maxp});
        apb(1'h1, `REG_TOTAL, tot);
        apb(1'h1, `REG_EVENTS, 32'h7);
        if (fresh) begin
            apb(1'h1, `REG_CONFIG, 32'h0);
            rtCnt = 0;
        end
        expCfg = {28'h0, dir, kind, 1'h1};
        apb(1'h1, `REG_CONFIG, expCfg);
        frameRoom <= room;
        intervalDue <= due;
        fifoValid <= {5'h0, len} + (sv ? 16'hFFFF : 16'(rnd(8)));
        fifoFree <= {5'h0, len} + (sv ? 16'hFFFF : 16'(rnd(8)));
        respSel <= resp;
        lenSel <= rx;
        delaySel <= 3'(rnd(8));
        chanSel <= 1'h1;
        t0 = nTok;
        r0 = nRel;
        c0 = nCom;
        h0 = nHs;
        @(posedge clock);
        chanSel <= 1'h0;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (busy !== 1'h0 && n < 100);
        if (busy !== 1'h0) hang();
        @(posedge clock);
        {ok, hs, com, expEv} = 6'h0;
        if (go) begin
            hs = dir && (resp == `RSP_TOGGLE || resp == `RSP_DATA && rx <= len);
            com = hs && resp == `RSP_DATA;
            if (st) begin
                expEv = 3'h2;
                expRc = `RC_STARVED;
            end else if (!dir && (kind == `KIND_ISO || resp == `RSP_ACK)) ok = 1;
            else if (dir && resp == `RSP_DATA && rx == len) ok = 1;
            else if (resp == `RSP_STALL) halt(`RC_STALL);
            else if (com) halt(`RC_SHORT);
            else if (dir && resp == `RSP_DATA) halt(`RC_BABBLE);
            else if (resp != `RSP_NAK) begin
                rtCnt++;
                expEv = 3'h2;
                expRc = `RC_RETRY;
                if (rtCnt == 3) halt(`RC_RETRY);
            end
        end
        if (ok) begin
            expEv = 3'h1;
            rtCnt = 0;
        end
        expTot = tot - ((ok && !dir) ? len : com ? rx : 11'h0);
        apb(1'h0, `REG_EVENTS, 32'h0);
        check(q, {29'h0, expEv});
        apb(1'h0, `REG_RESULT, 32'h0);
        check(q, {29'h0, expRc});
        apb(1'h0, `REG_CONFIG, 32'h0);
        check(q, expCfg);
        apb(1'h0, `REG_TOTAL, 32'h0);
        check(q, expTot);
        check(nTok - t0, 32'(go && !st));
        if (go && !st) check(lastTok, len);
        if (go && !st) check(lastIn, dir);
        check(nRel - r0, 32'(ok && !dir));
        check(nCom - c0, 32'(com));
        check(nHs - h0, 32'(hs));
        if (ok || com) check(lastFifo, dir ? rx : len);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h5B6F;
        {psel, penable, pwrite, chanSel, intervalDue, frameRoom} = 6'h0;
        {paddr, pwdata, fifoValid, fifoFree} = 76'h0;
        {respSel, lenSel, delaySel, expRc} = 20'h0;
        rstn = 1'h0;
        repeat (3) @(posedge clock);
        rstn <= 1'h1;
        // Reset contents of every register, then an unmapped word
        for (int i = 0; i < 5; i++) begin
            apb(1'h0, 12'(4 * i), 32'h0);
            check(q, (i == 1) ? {21'h0, `MAXPKT_RST} : 32'h0);
        end
        apb(1'h0, 12'h020, 32'h0);
        check({q[30:0], slvErr}, 32'h1);
        // Kind written as iso: the bulk-only probe still reads zero there
        apb(1'h1, `REG_CONFIG, 32'h4);
        apb(1'h0, `REG_CONFIG, 32'h0);
        check(q, 32'h4);
        check(qB, 32'h0);
        // Every link answer, OUT and IN
        for (int r = 0; r < 6; r++) begin
            runTx(1, 1, 0, `KIND_BULK, 64, 200, 3'(r), 0, 0);
            runTx(1, 1, 1, `KIND_BULK, 64, 32, 3'(r), 0, 0);
        end
        // Short and long IN, periodic OUT, starved iso
        runTx(1, 1, 1, `KIND_BULK, 64, 200, `RSP_DATA, 1, 0);
        runTx(1, 1, 1, `KIND_BULK, 64, 200, `RSP_DATA, 2, 0);
        runTx(1, 1, 0, `KIND_INTR, 8, 5, `RSP_STALL, 0, 0);
        runTx(1, 1, 0, `KIND_ISO, 16, 99, `RSP_NAK, 0, 1);
        runTx(1, 1, 0, `KIND_ISO, 16, 99, `RSP_NAK, 0, 0);
        // Three faults in a row
        for (int i = 0; i < 3; i++) runTx(i == 0, 1, 0, 0, 64, 200, 3, 0, 0);
        // Random mix
        for (int i = 0; i < 60; i++) begin
            d = rnd(2);
            runTx(1'(rnd(2)), 0, 1'(d), d ? 2'h0 : 2'(rnd(3)),
                11'(rnd(64) + 1), 32'(rnd(300) + 1), 3'(rnd(6)),
                2'(rnd(3)), rnd(3) == 0);
        end
        final_report();
    end
endmodule

// ===== tb/usb_peer_model.sv
`timescale 1ns/1ps
// Far endpoint: answers each token once, after a chosen delay
module usb_peer_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Token from the engine
    input wire logic tokReq,
    input wire logic tokIn,
    // Answer picked by the bench
    input wire logic [2:0] respSel,
    input wire logic [10:0] lenSel,
    input wire logic [2:0] delaySel,
    // Answer to the engine
    output logic linkDone,
    output logic [2:0] linkResp,
    output logic [10:0] rxLen
);
    logic pend_q; // Token seen, answer owed
    logic [2:0] left_q; // Cycles before the answer
    ////////////////////////////////////////////////////////////
    // Answer logic; idle fields toggle so stale values never match
    always_ff @(posedge clock) begin
        if (!rstn) begin
            pend_q <= 1'h0;
            left_q <= 3'h0;
            linkDone <= 1'h0;
            linkResp <= 3'h7;
            rxLen <= 11'h7FF;
        end else begin
            linkDone <= 1'h0;
            linkResp <= ~linkResp;
            rxLen <= ~rxLen;
            if (tokReq) begin
                pend_q <= 1'h1;
                left_q <= delaySel;
            end else if (pend_q && left_q == 3'h0) begin
                pend_q <= 1'h0;
                linkDone <= 1'h1;
                linkResp <= respSel;
                rxLen <= tokIn ? lenSel : ~rxLen;
            end else if (pend_q) begin
                left_q <= left_q - 3'h1;
            end
        end
    end
endmodule
